// ==== verilog/dvr_pkg.sv ====
// Constants for the velocity-change output register bank.
// Assumes one system clock and a serial link clock from the host.
package dvr_pkg;

	////////////////////////////////////////////////////////////////
	// Register byte addresses (seven-bit address field of a command)
	localparam logic [6:0] ADDR_X_LOW  = 7'h30;
	localparam logic [6:0] ADDR_X_HIGH = 7'h32;
	localparam logic [6:0] ADDR_Y_LOW  = 7'h34;
	localparam logic [6:0] ADDR_Y_HIGH = 7'h36;
	localparam logic [6:0] ADDR_Z_LOW  = 7'h38;
	localparam logic [6:0] ADDR_Z_HIGH = 7'h3a;
	localparam logic [6:0] ADDR_COUNT  = 7'h3c;
	localparam logic [6:0] ADDR_SUM    = 7'h3e;

	////////////////////////////////////////////////////////////////
	// Serial command word layout
	localparam int         CMD_WRITE_BIT = 15;  // One marks a write
	localparam int         CMD_ADDR_MSB  = 14;
	localparam int         CMD_ADDR_LSB  = 8;
	localparam logic [3:0] LAST_BIT      = 4'hf; // Sixteen bits a frame

	////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [31:0] DV_RESET   = 32'h0000_0000;
	localparam logic [47:0] ACC_RESET  = 48'h0000_0000_0000;

	////////////////////////////////////////////////////////////////
	// Rates and scaling
	localparam int RATE_LOW_SPS  = 2000;  // Selected when rate input is low
	localparam int RATE_HIGH_SPS = 4000;  // Twice the low rate: one more shift
	localparam int GAIN_FRAC     = 16;    // Fraction bits of the scale gain
	localparam int FS_SMALL      = 100;   // Full scale options, m/s
	localparam int FS_MID        = 125;
	localparam int FS_LARGE      = 400;

	// Saturation bounds of the 32-bit result
	localparam logic signed [63:0] DV_MAX = 64'sh0000_0000_7fff_ffff;
	localparam logic signed [63:0] DV_MIN = -64'sh0000_0000_8000_0000;

endpackage

// ==== verilog/dvr_regs.sv ====
// Velocity-change outputs, queue sample count and read byte-sum register,
// read by a host over a four-wire serial link (clock idles high).
// Assumes acceleration samples and control levels come from logic on i_mclk,
// and the host keeps chip select high for at least six i_mclk cycles between frames.
`timescale 1ns/1ns

module dvr_regs
#(
	parameter int DV_FULL_SCALE  = dvr_pkg::FS_SMALL, // Variant full scale, m/s
	parameter int ACCEL_LSB_UMS2 = 1000,              // Accel LSB, um/s^2
	parameter int QUEUE_DEPTH    = 256                // Queue capacity
)
(
	input  wire logic        i_mclk,          // System clock
	input  wire logic        i_sys_rst,       // Reset, high; synchronous on i_mclk, asynchronous for the link-side command capture
	input  wire logic        i_accel_valid,   // New acceleration sample
	input  wire logic [15:0] i_accel_x,       // Signed acceleration, x
	input  wire logic [15:0] i_accel_y,       // Signed acceleration, y
	input  wire logic [15:0] i_accel_z,       // Signed acceleration, z
	input  wire logic        i_rate_4k,       // High selects the fast rate
	input  wire logic [15:0] i_decimation,    // Decimation setting
	input  wire logic        i_queue_enable,  // Queue control bit 0
	input  wire logic        i_queue_discard, // Discard command pulse
	input  wire logic        i_queue_pop,     // Latest staged result to outputs
	input  wire logic        i_sclk,          // Link clock from host
	input  wire logic        i_cs_n,          // Link select, low
	input  wire logic        i_mosi,          // Host to device data
	output logic             o_miso,          // Device to host data
	output logic             o_data_ready     // Output load pulse
);

	////////////////////////////////////////////////////////////////
	// Scale gain: output LSB is full scale / 2^31 per accel-LSB / (2 fs)
	localparam longint unsigned GAIN = (64'd1 << 47) * 64'(ACCEL_LSB_UMS2)
		/ (64'd2 * 64'(dvr_pkg::RATE_LOW_SPS) * 64'(DV_FULL_SCALE) * 64'd1000000);

	// Saturate to the 32-bit two's complement range
	function automatic logic [31:0] sat32(input logic signed [63:0] v);
		if (v > dvr_pkg::DV_MAX)
			return dvr_pkg::DV_MAX[31:0];
		else if (v < dvr_pkg::DV_MIN)
			return dvr_pkg::DV_MIN[31:0];
		else
			return v[31:0];
	endfunction

	// Pair sum times 1/(2 fs); fast rate is exactly one shift more
	function automatic logic [31:0] scale(input logic signed [47:0] s, input logic fast);
		logic signed [63:0] p;
		p = (64'(s) * $signed(64'(GAIN))) >>> (dvr_pkg::GAIN_FRAC + int'(fast));
		return sat32(p);
	endfunction

	// High byte plus low byte, folded into sixteen bits
	function automatic logic [15:0] bytesum(input logic [15:0] w);
		return {8'h00, w[15:8]} + {8'h00, w[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////
	// Integration datapath
	logic signed [15:0] accel   [3];  // Current samples
	logic signed [15:0] a_prev  [3];  // Previous samples
	logic signed [47:0] acc     [3];  // Running pair sums
	logic signed [47:0] sum_out [3];  // Completed pair sums
	logic        [31:0] staged  [3];  // Scaled, waiting to load
	logic        [31:0] dv      [3];  // Output registers
	logic        [15:0] dec_cnt;      // Samples taken this update
	logic               upd;          // Pair sums complete
	logic               stage_rdy;    // Staged words valid
	logic               load;         // Output registers take a sample
	logic        [15:0] qcount;       // Queued sample count
	logic               last;         // This sample closes the update

	always_comb
	begin
		accel[0] = i_accel_x;
		accel[1] = i_accel_y;
		accel[2] = i_accel_z;
	end

	// Greater-or-equal guards against the setting shrinking mid-update
	assign last = dec_cnt >= i_decimation;

	// Decimation counter
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			dec_cnt <= dvr_pkg::WORD_RESET;
			upd     <= 1'b0;
		end
		else
		begin
			upd <= i_accel_valid && last;
			if (i_accel_valid)
				dec_cnt <= last ? dvr_pkg::WORD_RESET : dec_cnt + 16'h0001;
		end
	end

	// Pair accumulation per axis
	always_ff @(posedge i_mclk)
	begin
		for (int k = 0; k < 3; k++)
		begin
			if (i_sys_rst)
			begin
				acc[k]     <= dvr_pkg::ACC_RESET;
				sum_out[k] <= dvr_pkg::ACC_RESET;
				a_prev[k]  <= 16'sh0000;
			end
			else if (i_accel_valid)
			begin
				a_prev[k] <= accel[k];
				if (last)
				begin
					// Close the update with this pair and restart
					sum_out[k] <= acc[k] + 48'(accel[k]) + 48'(a_prev[k]);
					acc[k]     <= dvr_pkg::ACC_RESET;
				end
				else
					acc[k] <= acc[k] + 48'(accel[k]) + 48'(a_prev[k]);
			end
		end
	end

	// Scaling stage
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			stage_rdy <= 1'b0;
			for (int k = 0; k < 3; k++)
				staged[k] <= dvr_pkg::DV_RESET;
		end
		else
		begin
			stage_rdy <= upd;
			if (upd)
				for (int k = 0; k < 3; k++)
					staged[k] <= scale(sum_out[k], i_rate_4k);
		end
	end

	// Direct mode loads each new result; queued mode loads on pop
	assign load = i_queue_enable ? (i_queue_pop && qcount != dvr_pkg::WORD_RESET) : stage_rdy;

	// Output registers: all axes and both words in one edge
	always_ff @(posedge i_mclk)
	begin
		for (int k = 0; k < 3; k++)
		begin
			if (i_sys_rst)
				dv[k] <= dvr_pkg::DV_RESET;
			else if (load)
				dv[k] <= staged[k];
		end
	end

	// Queue count; held at zero outside queued mode
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst || !i_queue_enable || i_queue_discard)
			qcount <= dvr_pkg::WORD_RESET;
		else if (stage_rdy && !load && qcount < 16'(QUEUE_DEPTH))
			qcount <= qcount + 16'h0001;
		else if (load && !stage_rdy)
			qcount <= qcount - 16'h0001;
	end

	// Data ready pulse marks every output load
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			o_data_ready <= 1'b0;
		else
			o_data_ready <= load;
	end

	////////////////////////////////////////////////////////////////
	// Link side, on the host's clock
	logic [3:0]  bit_cnt;   // Rising edges in this frame
	logic [14:0] rx;        // Bits shifted in so far
	logic [15:0] cmd;       // Last complete command word
	logic        done_tgl;  // Flips once per finished frame
	logic [15:0] tx_word;   // Answer, owned by i_mclk

	// Frame counter and shifter; select high clears them
	always_ff @(posedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
		begin
			bit_cnt <= 4'h0;
			rx      <= 15'h0000;
		end
		else
		begin
			bit_cnt <= bit_cnt + 4'h1;
			rx      <= {rx[13:0], i_mosi};
		end
	end

	// Command capture on the sixteenth edge
	always_ff @(posedge i_sclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cmd      <= dvr_pkg::WORD_RESET;
			done_tgl <= 1'b0;
		end
		else if (bit_cnt == dvr_pkg::LAST_BIT)
		begin
			cmd      <= {rx, i_mosi};
			done_tgl <= ~done_tgl;
		end
	end

	// Answer bits change on falling edges; tx_word is quiet during a frame
	always_ff @(negedge i_sclk or posedge i_cs_n)
	begin
		if (i_cs_n)
			o_miso <= 1'b0;
		else
			o_miso <= tx_word[dvr_pkg::LAST_BIT - bit_cnt];
	end

	////////////////////////////////////////////////////////////////
	// Frame events into the system clock
	logic [2:0]  done_sync;   // Toggle synchroniser plus edge stage
	logic        evt;         // One frame finished
	logic [6:0]  cmd_addr;    // Address of finished command
	logic [15:0] next_tx;     // Looked-up answer
	logic        pend_valid;  // tx_word answers a read
	logic [6:0]  pend_addr;   // Address tx_word came from
	logic [15:0] sum;         // Read byte-sum register

	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
			done_sync <= 3'h0;
		else
			done_sync <= {done_sync[1:0], done_tgl};
	end

	assign evt      = done_sync[2] ^ done_sync[1];
	assign cmd_addr = cmd[dvr_pkg::CMD_ADDR_MSB:dvr_pkg::CMD_ADDR_LSB];

	// Register decode; unmapped reads answer zero
	always_comb
	begin
		case (cmd_addr)
			dvr_pkg::ADDR_X_LOW:  next_tx = dv[0][15:0];
			dvr_pkg::ADDR_X_HIGH: next_tx = dv[0][31:16];
			dvr_pkg::ADDR_Y_LOW:  next_tx = dv[1][15:0];
			dvr_pkg::ADDR_Y_HIGH: next_tx = dv[1][31:16];
			dvr_pkg::ADDR_Z_LOW:  next_tx = dv[2][15:0];
			dvr_pkg::ADDR_Z_HIGH: next_tx = dv[2][31:16];
			dvr_pkg::ADDR_COUNT:  next_tx = qcount;
			dvr_pkg::ADDR_SUM:    next_tx = sum;
			default:              next_tx = dvr_pkg::WORD_RESET;
		endcase
	end

	// Answer word for the next frame; writes are ignored
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst)
		begin
			tx_word    <= dvr_pkg::WORD_RESET;
			pend_valid <= 1'b0;
			pend_addr  <= 7'h00;
		end
		else if (evt)
		begin
			tx_word    <= next_tx;
			pend_valid <= !cmd[dvr_pkg::CMD_WRITE_BIT];
			pend_addr  <= cmd_addr;
		end
	end

	// Byte-sum of answers shipped; the sum's own reads are left out
	// A load in the same cycle wins: that read belonged to the old period
	always_ff @(posedge i_mclk)
	begin
		if (i_sys_rst || load)
			sum <= dvr_pkg::WORD_RESET;
		else if (evt && pend_valid && pend_addr != dvr_pkg::ADDR_SUM)
			sum <= sum + bytesum(tx_word);
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence s_full;
		i_accel_valid && dec_cnt >= i_decimation;
	endsequence

	sequence s_shipped;
		evt && pend_valid && pend_addr != dvr_pkg::ADDR_SUM && !load;
	endsequence

	property p_update_count;
		s_full |=> upd ##1 stage_rdy;
	endproperty
	a_update_count : assert property (p_update_count) else $error("update not raised after last sample");
	property p_no_early_update;
		upd |-> $past(i_accel_valid) && $past(dec_cnt) >= $past(i_decimation);
	endproperty
	a_no_early_update : assert property (p_no_early_update) else $error("update raised early");
	// Staged words come from the pair sums and rate that stood while upd was high
	property p_scaled;
		upd ##1 1 |-> staged[0] == scale($past(sum_out[0]), $past(i_rate_4k));
	endproperty
	a_scaled : assert property (p_scaled) else $error("staged x value not scaled");
	property p_coherent;
		!load |=> $stable(dv[0]) && $stable(dv[1]) && $stable(dv[2]);
	endproperty
	a_coherent : assert property (p_coherent) else $error("outputs changed without load");
	property p_discard;
		i_queue_discard |=> qcount == 16'h0000;
	endproperty
	a_discard : assert property (p_discard) else $error("discard did not clear count");
	property p_queue_off;
		!i_queue_enable |=> qcount == 16'h0000 ##1 !o_data_ready || !i_queue_enable;
	endproperty
	a_queue_off : assert property (p_queue_off) else $error("count nonzero outside queued mode");
	property p_push;
		i_queue_enable && stage_rdy && !load && !i_queue_discard && qcount < 16'(QUEUE_DEPTH)
			|=> qcount == $past(qcount) + 16'h0001;
	endproperty
	a_push : assert property (p_push) else $error("count did not rise on new sample");
	property p_sum_clear;
		load |=> sum == 16'h0000 && o_data_ready;
	endproperty
	a_sum_clear : assert property (p_sum_clear) else $error("byte-sum not cleared on load");
	property p_sum_add;
		s_shipped |=> sum == 16'($past(sum) + bytesum($past(tx_word)));
	endproperty
	a_sum_add : assert property (p_sum_add) else $error("byte-sum not advanced by answered word");
	property p_read_high;
		evt && cmd_addr == dvr_pkg::ADDR_X_HIGH |=> tx_word == $past(dv[0][31:16]);
	endproperty
	a_read_high : assert property (p_read_high) else $error("x high word answered wrongly");
endmodule

// ==== sim/dvr_host_model.sv ====
// Host side of the four-wire link: a master that frames 16-bit words.
// Assumes the bench calls xfer from one process, between frames only.
`timescale 1ns/1ns
module dvr_host_model
(
	output logic      o_sclk, // Link clock, still and high between frames
	output logic      o_cs_n, // Select, low for a whole frame
	output logic      o_mosi, // Command bits, most significant first
	input  wire logic i_miso  // Answer bits from the device
);
	////////////////////////////////////////////////////////////////
	// Idle levels; one select rise after time zero clears the device's frame logic,
	// since a value set at time zero may reach it without any edge
	initial
	begin
		o_sclk = 1'b1;
		o_cs_n = 1'b0;
		o_mosi = 1'b0;
		#2;
		o_cs_n = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// One frame; the answer carries the word asked for one frame earlier
	task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
		o_cs_n = 1'b0;
		#3;
		for (int i = 15; i >= 0; i--)
		begin
			// Bit changes on the falling edge, both sides sample on the rising one
			o_sclk = 1'b0;
			o_mosi = cmd[i];
			#3;
			o_sclk = 1'b1;
			rsp[i] = i_miso;
			#3;
		end
		o_cs_n = 1'b1;
		// A released line must not keep showing the last bit
		o_mosi = ~o_mosi;
		// Gap well above the six system cycles the device needs
		#90;
	endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the velocity-change register bank.
// Assumes dvr_host_model drives the link; the bench drives all else.
`timescale 1ns/1ns
module testbench;
	localparam int FS  = 100;  // Full scale, m/s
	localparam int LSB = 1000; // Accel LSB, um/s^2
	logic        i_mclk = 1'b0, i_sys_rst = 1'b0, i_accel_valid = 1'b0, i_rate_4k = 1'b0;
	logic        i_queue_enable, i_queue_discard, i_queue_pop, sclk, cs_n, mosi, miso, o_data_ready;
	logic [15:0] i_accel_x, i_accel_y, i_accel_z, i_decimation;
	logic [15:0] hsum = 16'h0000; // Host's own byte sum, wraps like the device's
	int          error_cnt = 0, check_count = 0, dr_cnt = 0;
	longint      psum[3], prev[3]; // Pair sums of the open update, last sample

	dvr_regs #(.DV_FULL_SCALE(FS), .ACCEL_LSB_UMS2(LSB), .QUEUE_DEPTH(256)) dvr_regs_inst
	(
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_accel_valid(i_accel_valid),
		.i_accel_x(i_accel_x), .i_accel_y(i_accel_y), .i_accel_z(i_accel_z),
		.i_rate_4k(i_rate_4k), .i_decimation(i_decimation), .i_queue_enable(i_queue_enable),
		.i_queue_discard(i_queue_discard), .i_queue_pop(i_queue_pop), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_data_ready(o_data_ready)
	);
	dvr_host_model dvr_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));

	always #5 i_mclk = ~i_mclk;

	// Count output loads as seen on the ready pulse
	always @(posedge i_mclk)
		if (o_data_ready === 1'b1)
			dr_cnt++;

	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("Checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Velocity results may differ by one code from the ideal real value
	task automatic chk(input string nm, input logic [31:0] e, g, input bit ex);
		check_count++;
		if (($signed(g - e) inside {-1, 0, 1}) !== 1'b1 || (ex && g !== e))
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ideal result from the pair sum, saturated to the 32-bit range
	function automatic logic [31:0] dv_exp(longint p);
		real r;
		r = p * 2.0 ** 31 * LSB / (2.0 * (i_rate_4k ? dvr_pkg::RATE_HIGH_SPS : dvr_pkg::RATE_LOW_SPS) * FS * 1.0e6);
		if (r > 2147483647.0)
			return 32'h7fff_ffff;
		if (r < -2147483648.0)
			return 32'h8000_0000;
		return 32'($rtoi($floor(r)));
	endfunction

	task automatic sync;
		@(posedge i_mclk);
		#1;
	endtask

	// One sample; the pair sum includes the sample before it
	task automatic samp(input logic [15:0] x, y, z);
		logic [15:0] a[3];
		a = '{x, y, z};
		sync;
		{i_accel_valid, i_accel_x, i_accel_y, i_accel_z} = {1'b1, x, y, z};
		sync;
		i_accel_valid = 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			psum[k] += longint'($signed(a[k])) + prev[k];
			prev[k] = longint'($signed(a[k]));
		end
	endtask

	task automatic pulse(ref logic p);
		sync;
		p = 1'b1;
		sync;
		p = 1'b0;
		repeat (5) @(posedge i_mclk);
	endtask

	// Read then a write, so the answer ships and no other word is summed
	task automatic rd(input logic [6:0] ad, output logic [15:0] d);
		logic [15:0] junk;
		dvr_host_model_inst.xfer({1'b0, ad, 8'h00}, junk);
		dvr_host_model_inst.xfer(16'hbe00, d);
		hsum += d[15:8] + d[7:0];
	endtask

	task automatic chk_sum;
		logic [15:0] s;
		dvr_host_model_inst.xfer(16'h3e00, s);
		dvr_host_model_inst.xfer(16'hbe00, s);
		chk("byte sum", 32'(hsum), 32'(s), 1'b1);
	endtask

	// High word first, to read out of address order
	task automatic chk_axes;
		logic [15:0] lo, hi;
		for (int k = 0; k < 3; k++)
		begin
			rd(7'(dvr_pkg::ADDR_X_HIGH + 4 * k), hi);
			rd(7'(dvr_pkg::ADDR_X_LOW + 4 * k), lo);
			chk("velocity change", dv_exp(psum[k]), {hi, lo}, 1'b0);
		end
	endtask

	task automatic chk_dr(input int e);
		repeat (5) @(posedge i_mclk);
		chk("ready pulses", 32'(e), 32'(dr_cnt), 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [15:0] d;
		for (int a = 'h30; a <= 'h40; a += 2)
		begin
			rd(7'(a), d);
			chk("reset value", 32'h0000_0000, 32'(d), 1'b1);
		end
		chk_sum;
	endtask

	task automatic t_direct;
		int n;
		n = dr_cnt;
		psum = '{0, 0, 0};
		samp(16'h03e8, 16'hf830, 16'h7fff);
		chk_dr(n + 1);
		hsum = 16'h0000;
		chk_axes;
		chk_sum;
	endtask

	task automatic t_decim;
		int n;
		sync;
		i_decimation = 16'h0002;
		i_rate_4k = 1'b1;
		n = dr_cnt;
		psum = '{0, 0, 0};
		samp(16'h8000, 16'h1234, 16'hff00);
		samp(16'h4000, 16'hedcc, 16'h0100);
		chk_dr(n);
		samp(16'hc000, 16'h7fff, 16'h0001);
		chk_dr(n + 1);
		chk_axes;
	endtask

	task automatic t_sat;
		logic [15:0] d;
		sync;
		i_decimation = 16'h1837;
		i_rate_4k = 1'b0;
		psum = '{0, 0, 0};
		repeat (6200) samp(16'h7fff, 16'h7fff, 16'h7fff);
		hsum = 16'h0000;
		chk_axes;
		repeat (150)
		begin
			rd(dvr_pkg::ADDR_X_HIGH, d);
			rd(dvr_pkg::ADDR_X_LOW, d);
		end
		chk_sum;
		psum = '{0, 0, 0};
		repeat (6200) samp(16'h8000, 16'h8000, 16'h8000);
		chk_axes;
	endtask

	// A new sample between two reads restarts the device sum
	task automatic t_bound;
		logic [15:0] d;
		int          n;
		sync;
		i_decimation = 16'h0000;
		rd(dvr_pkg::ADDR_Z_HIGH, d);
		psum = '{0, 0, 0};
		n = dr_cnt;
		samp(16'h0010, 16'h0020, 16'h0030);
		chk_dr(n + 1);
		hsum = 16'h0000;
		rd(dvr_pkg::ADDR_Y_LOW, d);
		chk_sum;
	endtask

	task automatic t_queue;
		logic [15:0] d;
		int          n;
		sync;
		i_queue_enable = 1'b1;
		n = dr_cnt;
		repeat (3)
		begin
			psum = '{0, 0, 0};
			samp(16'h0100, 16'hfe00, 16'h0300);
		end
		chk_dr(n);
		rd(dvr_pkg::ADDR_COUNT, d);
		chk("queue count", 32'h0000_0003, 32'(d), 1'b1);
		pulse(i_queue_pop);
		chk_dr(n + 1);
		hsum = 16'h0000;
		chk_axes;
		chk_sum;
		rd(dvr_pkg::ADDR_COUNT, d);
		chk("queue count", 32'h0000_0002, 32'(d), 1'b1);
		pulse(i_queue_discard);
		rd(dvr_pkg::ADDR_COUNT, d);
		chk("queue count", 32'h0000_0000, 32'(d), 1'b1);
		pulse(i_queue_pop);
		chk_dr(n + 1);
		sync;
		i_queue_enable = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		{i_accel_x, i_accel_y, i_accel_z, i_decimation} = '0;
		{i_queue_enable, i_queue_discard, i_queue_pop} = '0;
		psum = '{0, 0, 0};
		prev = '{0, 0, 0};
		// Raised after time zero so the link-side command capture flops see a reset edge
		#1;
		i_sys_rst = 1'b1;
		repeat (10) @(posedge i_mclk);
		#1;
		i_sys_rst = 1'b0;
		t_reset;
		t_direct;
		t_decim;
		t_sat;
		t_bound;
		t_queue;
		give_verdict;
	end

	// Watchdog: the whole sequence needs about half this span
	initial
	begin
		#800000;
		error_cnt++;
		give_verdict;
	end
endmodule
